// ===== hw/fbp_guard.sv
// Protection checker: decides whether one request may touch the array.
`timescale 1ns/1ps
`default_nettype none
module fbp_guard (
    // Request and verdict.
    fbp_chk_if.guard chk
);

    // ------------------------------------------------------------
    // Region lookup
    // ------------------------------------------------------------

    // Region index is the byte address over 2 KB.
    logic [fbp_pkg::REG_W-1:0] region;

    assign region = chk.addr[fbp_pkg::REG_LSB +: fbp_pkg::REG_W];

    // Each region owns its own two-bit field of the vector.
    assign chk.mode = chk.in_range ? chk.prot[2*region +: 2] : fbp_pkg::PROT_OPEN;

    // Anything past 96 KB is outside the array.
    assign chk.in_range = (chk.addr < fbp_pkg::ADDR_LIMIT);

    // ------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------

    // Open, read-only and execute-only settings are told apart here.
    always_comb begin
        chk.allow = 1'b0;
        if (!chk.in_range) begin
            // Out of range: always refused.
            chk.allow = 1'b0;
        end else if (chk.mode == fbp_pkg::PROT_OPEN) begin
            // Unprotected region: everything goes.
            chk.allow = 1'b1;
        end else if (chk.mode == fbp_pkg::PROT_RO) begin
            // Read-only: any read, no change.
            chk.allow = (chk.kind != fbp_pkg::FBP_PROG) && (chk.kind != fbp_pkg::FBP_ERASE);
        end else begin
            // Execute-only: only instruction fetch reaches data.
            chk.allow = (chk.kind == fbp_pkg::FBP_FETCH);
        end
    end

endmodule
`default_nettype wire

// ===== hw/fbp_top.sv
// Flash array with block erase and per-region read/execute protection.
`timescale 1ns/1ps
`default_nettype none
module fbp_top (
    // Clock and reset.
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // Request port.
    input  wire logic                        req_valid,
    input  wire logic [2:0]                  req_kind,
    input  wire logic [fbp_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic [fbp_pkg::DATA_W-1:0]  req_wdata,
    // Protection settings, two bits per 2 KB region.
    input  wire logic [fbp_pkg::PROT_W-1:0]  prot_mode,
    // Answer port.
    output logic                             rsp_valid,
    output logic                             rsp_error,
    output logic [fbp_pkg::DATA_W-1:0]       rsp_rdata,
    output logic                             busy
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    // All controller state in one record.
    // A single record keeps the next-state and register views in step.
    typedef struct packed {
        fbp_pkg::fbp_state_t        st;     // Idle or clearing a block.
        logic [fbp_pkg::BLK_W-1:0]  blk;    // Block being erased.
        logic [fbp_pkg::PTR_W-1:0]  ptr;    // Next word to clear.
        logic                       rvld;   // Answer strobe.
        logic                       rerr;   // Access violation.
        logic [fbp_pkg::DATA_W-1:0] rdata;  // Read data.
        logic                       busy;   // Erase in progress.
    } fbp_regs_t;

    fbp_regs_t s;       // Current state.
    fbp_regs_t next_s;  // Next state.

    // The array itself; contents are kept across reset like real flash.
    // It is read combinationally into the answer register for one-cycle reads.
    logic [fbp_pkg::DATA_W-1:0] mem [fbp_pkg::WORDS];

    // Array write port, driven from the controller logic.
    logic                        wr_en;
    logic [fbp_pkg::WIDX_W-1:0]  wr_idx;
    logic [fbp_pkg::DATA_W-1:0]  wr_data;

    // A request is only taken while no erase is running.
    logic                        accept;
    fbp_pkg::fbp_kind_t          kind;
    logic                        kind_ok;   // Known request code.
    logic                        is_read;   // Any of the three reads.
    logic [fbp_pkg::WIDX_W-1:0]  req_idx;   // Word index of request.

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Byte address to word index, used for reads and programming.
    function automatic logic [fbp_pkg::WIDX_W-1:0] word_of(
        input logic [fbp_pkg::ADDR_W-1:0] a
    );
        word_of = a[fbp_pkg::WORD_LSB +: fbp_pkg::WIDX_W];
    endfunction

    // Block number and word-in-block back to a word index.
    // Block bits sit above the word pointer, so a sweep cannot leave its block.
    function automatic logic [fbp_pkg::WIDX_W-1:0] idx_of(
        input logic [fbp_pkg::BLK_W-1:0] b,
        input logic [fbp_pkg::PTR_W-1:0] p
    );
        idx_of = {b, p};
    endfunction

    // ------------------------------------------------------------
    // Protection check
    // ------------------------------------------------------------

    // The checker is pure logic, so its verdict is ready in the taking cycle.
    fbp_chk_if chk ();

    // Request fields go to the checker unregistered.
    assign chk.addr = req_addr;
    assign chk.kind = kind;
    assign chk.prot = prot_mode;

    fbp_guard u_guard (
        .chk (chk.guard)
    );

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------

    // Undefined kind codes fall into the violation path below.
    // Address bits 1:0 are ignored; only whole words are served.
    assign kind    = fbp_pkg::fbp_kind_t'(req_kind);
    assign kind_ok = (req_kind <= 3'(fbp_pkg::FBP_ERASE));
    assign is_read = (kind == fbp_pkg::FBP_FETCH) || (kind == fbp_pkg::FBP_DATA) ||
                     (kind == fbp_pkg::FBP_DEBUG);
    assign accept  = req_valid && (s.st == fbp_pkg::FBP_IDLE);
    assign req_idx = word_of(req_addr);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // One pass computes both the next record and the array write.
    // The answer strobe defaults low so that it stands for one cycle only.
    always_comb begin
        next_s      = s;
        next_s.rvld = 1'b0;
        wr_en       = 1'b0;
        wr_idx      = req_idx;
        wr_data     = fbp_pkg::ERASED_WORD;
        case (s.st)
            fbp_pkg::FBP_IDLE: begin
                // Requests are taken only here; a running sweep ignores them.
                if (accept) begin
                    next_s.rvld  = 1'b1;
                    next_s.rerr  = 1'b0;
                    next_s.rdata = fbp_pkg::ZERO_WORD;
                    if (!chk.allow || !kind_ok) begin
                        // Refused: no write, no data, violation flagged.
                        // The kind check also catches the three unused codes.
                        next_s.rerr = 1'b1;
                    end else if (is_read) begin
                        // Permitted read, answered at the next edge.
                        next_s.rdata = mem[req_idx];
                    end else if (kind == fbp_pkg::FBP_PROG) begin
                        // Programming can only clear bits, as on real flash.
                        wr_en   = 1'b1;
                        wr_data = mem[req_idx] & req_wdata;
                    end else begin
                        // Erase starts; answer comes at the end of it.
                        // A refused erase never gets here, so busy never rises for it.
                        next_s.rvld = 1'b0;
                        next_s.st   = fbp_pkg::FBP_CLEAR;
                        next_s.blk  = req_addr[fbp_pkg::BLK_LSB +: fbp_pkg::BLK_W];
                        next_s.ptr  = '0;
                    end
                end
            end
            fbp_pkg::FBP_CLEAR: begin
                // One word of the chosen block per cycle, set to ones.
                wr_en   = 1'b1;
                wr_idx  = idx_of(s.blk, s.ptr);
                wr_data = fbp_pkg::ERASED_WORD;
                // The pointer wraps from the last word back to zero.
                next_s.ptr = s.ptr + fbp_pkg::PTR_ONE;
                // The last word ends the sweep and releases the answer.
                if (s.ptr == fbp_pkg::LAST_PTR) begin
                    next_s.st    = fbp_pkg::FBP_IDLE;
                    next_s.rvld  = 1'b1;
                    next_s.rerr  = 1'b0;
                    next_s.rdata = fbp_pkg::ZERO_WORD;
                end
            end
            default: begin
                // Unreachable codes recover to idle rather than lock up.
                next_s.st = fbp_pkg::FBP_IDLE;
            end
        endcase
        next_s.busy = (next_s.st == fbp_pkg::FBP_CLEAR);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Controller record; the array is not reset on purpose.
    // A reset in mid-sweep leaves part of a block cleared and part not;
    // that block must be erased again before its contents are trusted.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s.st    <= fbp_pkg::FBP_IDLE;
            s.blk   <= '0;
            s.ptr   <= '0;
            s.rvld  <= 1'b0;
            s.rerr  <= 1'b0;
            s.rdata <= fbp_pkg::ZERO_WORD;
            s.busy  <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // Array write port. Only this block's words change on erase.
    // Kept apart from the record so that the array needs no reset network.
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Outputs come straight from the record.
    // Each output is a register field, so no logic sits after the flops.
    assign rsp_valid = s.rvld;
    assign rsp_error = s.rerr;
    assign rsp_rdata = s.rdata;
    assign busy      = s.busy;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    // All checks are off during reset, while the record is being cleared.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Helper: request with a given region setting.
    // Both execute-only codes have the upper bit set.
    logic hit_xo;
    logic hit_ro;

    assign hit_xo = chk.in_range && chk.mode[1];
    assign hit_ro = chk.in_range && (chk.mode == fbp_pkg::PROT_RO);

    // A permitted read is answered at the very next edge, error clear.
    chk_read_one_cycle: assert property (
        accept && is_read && chk.allow |=> rsp_valid && !rsp_error
    ) else $error("Permitted read not answered in one cycle.");

    // Data and debug reads of an execute-only pair get nothing back.
    chk_xo_data_read: assert property (
        accept && hit_xo && (kind == fbp_pkg::FBP_DATA || kind == fbp_pkg::FBP_DEBUG)
        |=> rsp_valid && rsp_error && rsp_rdata == fbp_pkg::ZERO_WORD
    ) else $error("Execute-only region returned data to a non-fetch read.");

    // Fetches still reach execute-only code, or it could never run.
    chk_xo_fetch_ok: assert property (
        accept && hit_xo && kind == fbp_pkg::FBP_FETCH |=> rsp_valid && !rsp_error
    ) else $error("Instruction fetch from execute-only region refused.");

    // Read-only pairs see no write strobe, and no erase sweep begins.
    chk_ro_no_change: assert property (
        accept && hit_ro && (kind == fbp_pkg::FBP_PROG || kind == fbp_pkg::FBP_ERASE)
        |-> !wr_en ##1 rsp_error && !busy
    ) else $error("Read-only region was modified.");

    // Execute-only pairs are as safe from change as read-only ones.
    chk_xo_no_change: assert property (
        accept && hit_xo && (kind == fbp_pkg::FBP_PROG || kind == fbp_pkg::FBP_ERASE)
        |-> !wr_en ##1 rsp_error && !busy
    ) else $error("Execute-only region was modified.");

    // Every sweep cycle writes the erased pattern and nothing else.
    chk_erase_ones: assert property (
        s.st == fbp_pkg::FBP_CLEAR |-> wr_en && wr_data == fbp_pkg::ERASED_WORD
    ) else $error("Erase wrote a word other than all ones.");

    // The sweep stays inside the chosen block, so neighbours survive.
    chk_erase_in_block: assert property (
        s.st == fbp_pkg::FBP_CLEAR |-> wr_idx[fbp_pkg::WIDX_W-1 -: fbp_pkg::BLK_W] == s.blk
    ) else $error("Erase touched a word outside its block.");

    // Busy spans exactly one word per cycle for the whole block.
    chk_erase_length: assert property (
        accept && kind == fbp_pkg::FBP_ERASE && chk.allow
        |=> busy ##255 busy ##1 !busy && rsp_valid && !rsp_error
    ) else $error("Erase did not take exactly one block sweep.");

    // A protection refusal leaves the array alone and flags the requester.
    chk_refuse_flag: assert property (
        accept && !chk.allow |-> !wr_en ##1 rsp_valid && rsp_error &&
        rsp_rdata == fbp_pkg::ZERO_WORD
    ) else $error("Refused request changed data or missed its violation.");

    // Addresses past the array end can never be served.
    chk_range_limit: assert property (
        accept && !chk.in_range |=> rsp_error
    ) else $error("Access beyond the 96 KB array was accepted.");

    // A code outside the five kinds is refused even in an open pair.
    chk_bad_kind: assert property (
        accept && !kind_ok |-> !wr_en ##1 rsp_valid && rsp_error && rsp_rdata == fbp_pkg::ZERO_WORD
    ) else $error("Undefined request kind was not refused.");

    // Requests that arrive mid-sweep are dropped without an answer.
    chk_sweep_quiet: assert property (
        s.st == fbp_pkg::FBP_CLEAR && s.ptr != fbp_pkg::LAST_PTR |=> busy && !rsp_valid
    ) else $error("Answer or idle seen in the middle of an erase.");

    // Outside a sweep only a permitted program may write the array.
    chk_no_stray_write: assert property (
        s.st == fbp_pkg::FBP_IDLE && !(accept && kind == fbp_pkg::FBP_PROG && chk.allow) |-> !wr_en
    ) else $error("Array written without a permitted program.");

endmodule
`default_nettype wire

// ===== shared/fbp_chk_if.sv
// Interface carrying a request to the protection checker and its verdict.
`timescale 1ns/1ps
`default_nettype none
interface fbp_chk_if;
    logic [fbp_pkg::ADDR_W-1:0] addr;      // Byte address.
    fbp_pkg::fbp_kind_t         kind;      // Request kind.
    logic [fbp_pkg::PROT_W-1:0] prot;      // All region settings.
    logic [1:0]                 mode;      // Setting of the region hit.
    logic                       in_range;  // Address inside the array.
    logic                       allow;     // Request may proceed.

    modport guard (input addr, kind, prot, output mode, in_range, allow);
    modport user  (output addr, kind, prot, input mode, in_range, allow);
endinterface
`default_nettype wire

// ===== shared/fbp_pkg.sv
// Shared constants and types for the flash block protection logic.
package fbp_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int FLASH_BYTES  = 98304;  // 96 KB array.
    localparam int BLOCK_BYTES  = 1024;   // Erase unit.
    localparam int REGION_BYTES = 2048;   // Protection unit.
    localparam int WORD_BYTES   = 4;
    localparam int ADDR_W       = 17;
    localparam int DATA_W       = 32;
    localparam int WORDS        = FLASH_BYTES / WORD_BYTES;
    localparam int BLOCK_WORDS  = BLOCK_BYTES / WORD_BYTES;
    localparam int NUM_BLOCKS   = FLASH_BYTES / BLOCK_BYTES;
    localparam int NUM_REGIONS  = FLASH_BYTES / REGION_BYTES;
    localparam int WIDX_W       = 15;     // Word index width.
    localparam int PTR_W        = 8;      // Word within a block.
    localparam int BLK_W        = 7;      // Block number width.
    localparam int REG_W        = 6;      // Region number width.
    localparam int WORD_LSB     = 2;      // Byte address to word.
    localparam int BLK_LSB      = 10;     // Byte address to block.
    localparam int REG_LSB      = 11;     // Byte address to region.
    localparam int PROT_W       = 2 * NUM_REGIONS;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;
    localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h00000000;
    localparam logic [PTR_W-1:0]  LAST_PTR    = 8'hff;
    localparam logic [PTR_W-1:0]  PTR_ONE     = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT  = 17'h18000;

    // Per-region protection codes, two bits per region.
    localparam logic [1:0] PROT_OPEN = 2'h0;
    localparam logic [1:0] PROT_RO   = 2'h1;
    localparam logic [1:0] PROT_XO   = 2'h2;
    localparam logic [1:0] PROT_XO2  = 2'h3;  // Treated as execute-only.

    // Request kinds.
    typedef enum logic [2:0] {
        FBP_FETCH = 3'h0,  // Processor instruction fetch.
        FBP_DATA  = 3'h1,  // Processor data read.
        FBP_DEBUG = 3'h2,  // Debugger read.
        FBP_PROG  = 3'h3,  // Program one word.
        FBP_ERASE = 3'h4   // Erase one 1 KB block.
    } fbp_kind_t;

    // Controller states, one-hot.
    typedef enum logic [1:0] {
        FBP_IDLE  = 2'b01,
        FBP_CLEAR = 2'b10
    } fbp_state_t;

endpackage

// ===== testbench/fbp_requester.sv
// Requester model: processor fetch and data paths plus the debug path.
`timescale 1ns/1ps
`default_nettype none
module fbp_requester (
    // Clock.
    input  wire logic                       ref_clk,
    // Request side.
    output logic                            req_valid,
    output logic [2:0]                      req_kind,
    output logic [fbp_pkg::ADDR_W-1:0]      req_addr,
    output logic [fbp_pkg::DATA_W-1:0]      req_wdata,
    // Answer side.
    input  wire logic                       rsp_valid,
    input  wire logic                       rsp_error,
    input  wire logic [fbp_pkg::DATA_W-1:0] rsp_rdata,
    input  wire logic                       busy
);
    // Quiet bus at time zero.
    initial begin
        req_valid = 1'b0;
        req_kind  = 3'h0;
        req_addr  = 17'h00000;
        req_wdata = 32'h00000000;
    end

    // One request, held until the taking edge, then the answer is collected.
    // Released lines show the inverse of the last value, so nothing stale matches.
    task automatic issue(input logic [2:0] kind, input logic [16:0] addr, input logic [31:0] wdata,
                         output logic err, output logic [31:0] rdata, output int lat);
        int n;
        lat   = -1;
        err   = 1'bx;
        rdata = 32'hxxxxxxxx;
        @(posedge ref_clk);
        #1;
        for (n = 0; n < 300 && busy !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        req_valid = 1'b1;
        req_kind  = kind;
        req_addr  = addr;
        req_wdata = wdata;
        @(posedge ref_clk);
        #1;
        req_valid = 1'b0;
        req_kind  = ~kind;
        req_addr  = ~addr;
        req_wdata = ~wdata;
        // The answer pulse lasts one cycle, so look at every cycle.
        for (n = 1; n <= 300 && lat < 0; n++) begin
            if (rsp_valid === 1'b1) begin
                lat   = n;
                err   = rsp_error;
                rdata = rsp_rdata;
            end else begin
                @(posedge ref_clk);
                #1;
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== testbench/fbp_tb_top.sv
// Self-checking testbench for the flash block protection logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module fbp_tb_top;
    logic        ref_clk   = 1'b0; // 200 MHz clock.
    logic        rst       = 1'b1; // Reset, active high.
    logic [95:0] prot_mode = '0;   // Region settings.
    logic        req_valid;
    logic [2:0]  req_kind;
    logic [16:0] req_addr;
    logic [31:0] req_wdata;
    logic        rsp_valid;
    logic        rsp_error;
    logic [31:0] rsp_rdata;
    logic        busy;
    int          fail_count = 0;  // Mismatches seen.
    int          tests_run  = 0;  // Comparisons made.

    always #2.5 ref_clk = ~ref_clk;

    fbp_top u_fbp_top (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_kind(req_kind),
        .req_addr(req_addr), .req_wdata(req_wdata), .prot_mode(prot_mode), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .busy(busy));
    fbp_requester u_fbp_requester (.ref_clk(ref_clk), .req_valid(req_valid), .req_kind(req_kind),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .busy(busy));

    // ----------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One request with its expected status, data and latency.
    task automatic op(input logic [2:0] kind, input logic [16:0] addr, input logic [31:0] wdata,
                      input logic exp_err, input logic [31:0] exp_data, input int exp_lat);
        logic        err;
        logic [31:0] rdata;
        int          lat;
        u_fbp_requester.issue(kind, addr, wdata, err, rdata, lat);
        `CHK(err, exp_err)
        `CHK(rdata, exp_data)
        `CHK(lat, exp_lat)
    endtask

    // Sets the protection code of one 2 KB region.
    task automatic set_mode(input int r, input logic [1:0] code);
        prot_mode[2*r +: 2] = code;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    // Erase fills with ones and spares neighbours; program only clears bits.
    task automatic t_erase();
        fork
            op(3'h4, 17'h00000, 32'h0, 1'b0, 32'h0, 257);
            begin
                // Busy must stand through the middle of the sweep.
                repeat (100) @(posedge ref_clk);
                #1;
                `CHK(busy, 1'b1)
            end
        join
        `CHK(busy, 1'b0)
        op(3'h4, 17'h00400, 32'h0, 1'b0, 32'h0, 257);
        op(3'h3, 17'h00400, 32'h12345678, 1'b0, 32'h0, 1);
        op(3'h3, 17'h00400, 32'hff00ffff, 1'b0, 32'h0, 1);
        op(3'h4, 17'h003fc, 32'h0, 1'b0, 32'h0, 257);
        op(3'h0, 17'h003fc, 32'h0, 1'b0, 32'hffffffff, 1);
        op(3'h2, 17'h00000, 32'h0, 1'b0, 32'hffffffff, 1);
        op(3'h1, 17'h00400, 32'h0, 1'b0, 32'h12005678, 1);
        $display("Test erase done");
    endtask

    // Read-only pair: all reads served, writes refused; next pair stays open.
    task automatic t_ro();
        set_mode(0, fbp_pkg::PROT_RO);
        op(3'h3, 17'h00404, 32'h0, 1'b1, 32'h0, 1);
        op(3'h4, 17'h00400, 32'h0, 1'b1, 32'h0, 1);
        op(3'h1, 17'h00400, 32'h0, 1'b0, 32'h12005678, 1);
        op(3'h0, 17'h00404, 32'h0, 1'b0, 32'hffffffff, 1);
        op(3'h2, 17'h00400, 32'h0, 1'b0, 32'h12005678, 1);
        op(3'h4, 17'h00800, 32'h0, 1'b0, 32'h0, 257);
        op(3'h3, 17'h00800, 32'h0000ffff, 1'b0, 32'h0, 1);
        op(3'h1, 17'h00800, 32'h0, 1'b0, 32'h0000ffff, 1);
        $display("Test read-only done");
    endtask

    // Execute-only pair under both codes: fetch only, the rest refused.
    task automatic t_xo();
        logic [1:0] codes [2];
        codes = '{fbp_pkg::PROT_XO, fbp_pkg::PROT_XO2};
        foreach (codes[i]) begin
            set_mode(1, codes[i]);
            op(3'h0, 17'h00800, 32'h0, 1'b0, 32'h0000ffff, 1);
            op(3'h1, 17'h00800, 32'h0, 1'b1, 32'h0, 1);
            op(3'h2, 17'h00800, 32'h0, 1'b1, 32'h0, 1);
            op(3'h3, 17'h00800, 32'h0, 1'b1, 32'h0, 1);
            op(3'h4, 17'h00c00, 32'h0, 1'b1, 32'h0, 1);
        end
        set_mode(1, fbp_pkg::PROT_OPEN);
        op(3'h1, 17'h00800, 32'h0, 1'b0, 32'h0000ffff, 1);
        $display("Test execute-only done");
    endtask

    // Top of the array, first address beyond it and an undefined kind.
    task automatic t_range();
        op(3'h4, 17'h17c00, 32'h0, 1'b0, 32'h0, 257);
        op(3'h1, 17'h17ffc, 32'h0, 1'b0, 32'hffffffff, 1);
        op(3'h0, 17'h18000, 32'h0, 1'b1, 32'h0, 1);
        op(3'h5, 17'h00000, 32'h0, 1'b1, 32'h0, 1);
        $display("Test range done");
    endtask

    // Reset in mid-run clears the answer port but keeps the array.
    task automatic t_reset();
        op(3'h5, 17'h00000, 32'h0, 1'b1, 32'h0, 1);
        rst = 1'b1;
        #1;
        `CHK(rsp_valid, 1'b0)
        `CHK(rsp_error, 1'b0)
        `CHK(busy, 1'b0)
        @(posedge ref_clk);
        #1;
        rst = 1'b0;
        op(3'h1, 17'h00400, 32'h0, 1'b0, 32'h12005678, 1);
        $display("Test reset done");
    endtask

    // ----------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        t_erase();
        t_ro();
        t_xo();
        t_range();
        t_reset();
        report_and_stop();
    end

    // The run needs about 1350 cycles; over twenty times that means a hang.
    initial begin
        #150000;
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
